// file: design/field_be_split.sv
// Splits a 16-bit field into its two payload bytes, most significant first.
// Assumes the caller supplies a byte position inside the field (0 or 1).
`timescale 1ns/10ps
module field_be_split
    import flash_cmd_pkg::*;
(
    input wire logic [15:0] field_value,
    input wire logic lo_byte,
    output logic [7:0] byte_out
);
    // The high byte travels first on the stream.
    assign byte_out = lo_byte ? field_value[7:0] : field_value[15:8];
endmodule

// file: design/flash_cmd_handler.sv
// Command handler for the general flash store: takes request payload bytes,
// decodes the eight-byte header and streams the matching reply payload.
// Assumes the transport delivers payload bytes with endpoint, cluster and
// broadcast/source endpoint information held steady from first byte to last.
//
// How it works
// - Store has 119 blocks of 512 bytes, reported as geometry.
// - Only requests to cluster 0x23 on endpoint 0xe6 are handled.
// - Byte 0 holds command code, byte 1 command options.
// - Block number at byte 2, byte index at 4, byte count at 6.
// - Data bytes start at byte 8, counted by the byte count field.
// - Multi-byte fields go most significant byte first.
// - A unicast request gets a unicast reply to its source endpoint.
// - Broadcast requests get no reply at all.
// - Reply goes out as explicit frame; flag marks source endpoint 0xe6.
// - Reply mirrors request layout, byte 1 carries result status.
// - Reply code derives from request code by setting the top bit.
// - A unicast geometry query is answered with code 0x80.
// - Status bit 0 set means failure; other status bits zero.
// - Geometry reply block number field carries the block count.
// - Geometry reply byte index field carries the block size.
// - Geometry reply byte count is zero with no data bytes.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module flash_cmd_handler
    import flash_cmd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic req_valid,
    input wire logic [7:0] req_byte,
    input wire logic req_last,
    input wire logic req_broadcast,
    input wire logic [7:0] req_dest_endpoint,
    input wire logic [15:0] req_cluster,
    input wire logic [7:0] req_src_endpoint,
    output logic rsp_valid,
    output logic [7:0] rsp_byte,
    output logic rsp_last,
    output logic [7:0] rsp_dest_endpoint,
    output logic rsp_explicit,
    input wire logic rsp_ready,
    output logic busy,
    output logic irq
);
    // =====================================================================
    // Request collection
    // =====================================================================
    cmd_state_e state_reg;
    logic [3:0] hdr_pos_reg;
    logic [7:0] code_reg;
    logic [15:0] block_reg;
    logic [15:0] index_reg;
    logic [15:0] count_reg;
    logic [7:0] src_ep_reg;
    logic drop_reg;
    logic short_reg;
    logic [7:0] ctrl_reg;
    logic [EV_WIDTH-1:0] mask_reg;
    logic [EV_WIDTH-1:0] events;
    logic [EV_WIDTH-1:0] ev_set;
    logic ev_clear;
    logic [7:0] last_code_reg;
    logic [3:0] send_pos_reg;
    logic [7:0] rsp_code;
    logic [7:0] rsp_status;
    logic [15:0] rsp_blk;
    logic [15:0] rsp_idx;
    logic [15:0] rsp_cnt;
    logic [7:0] blk_byte;
    logic [7:0] idx_byte;
    logic [7:0] cnt_byte;
    logic [7:0] byte_next;
    logic addressed;
    logic known_code;
    logic finish;
    logic will_reply;

    // Requests for other clusters or endpoints pass by untouched.
    assign addressed = (req_cluster == MEM_CLUSTER) && (req_dest_endpoint == MEM_ENDPOINT);
    assign known_code = (code_reg == CODE_GEOMETRY_QUERY);
    assign finish = req_valid && req_last && (state_reg == ST_COLLECT);
    // Broadcast, short and, when disabled, unknown requests are dropped.
    // A payload that ends on the low count byte is complete even though the
    // short flag only clears at that same edge.
    assign will_reply = !drop_reg && !(short_reg && hdr_pos_reg != OFS_CNT_LO)
        && (known_code || ctrl_reg[CTRL_ANSWER_UNKNOWN]);

    // Main sequencer: idle, collect header and data, send the reply.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            send_pos_reg <= 4'h0;
        end else if (clk_en) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (req_valid && ctrl_reg[CTRL_ENABLE] && addressed) begin
                        state_reg <= req_last ? ST_IDLE : ST_COLLECT;
                    end
                end
                ST_COLLECT: begin
                    if (finish) begin
                        state_reg <= will_reply ? ST_SEND : ST_IDLE;
                        send_pos_reg <= OFS_CODE;
                    end
                end
                ST_SEND: begin
                    // Advance as each byte enters the output stage, so no byte repeats.
                    if (!rsp_valid || rsp_ready) begin
                        if (send_pos_reg == HDR_LAST) begin
                            state_reg <= ST_IDLE; // No data bytes follow.
                        end
                        send_pos_reg <= send_pos_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // Header capture: big-endian fields at fixed offsets; data bytes past
    // offset 8 are neither counted nor stored since no command here uses them.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hdr_pos_reg <= 4'h0;
            code_reg <= 8'h00;
            block_reg <= 16'h0000;
            index_reg <= 16'h0000;
            count_reg <= 16'h0000;
            src_ep_reg <= 8'h00;
            drop_reg <= 1'b0;
            short_reg <= 1'b0;
        end else if (clk_en && req_valid) begin
            if (state_reg == ST_IDLE) begin
                hdr_pos_reg <= OFS_OPT;
                code_reg <= req_byte;
                src_ep_reg <= req_src_endpoint;
                drop_reg <= req_broadcast;
                short_reg <= 1'b1;
            end else if (state_reg == ST_COLLECT) begin
                if (hdr_pos_reg != HDR_BYTES) begin
                    hdr_pos_reg <= hdr_pos_reg + 4'h1;
                end
                // Options are accepted and ignored by every known command.
                unique case (hdr_pos_reg)
                    OFS_BLK_HI: block_reg[15:8] <= req_byte;
                    OFS_BLK_LO: block_reg[7:0] <= req_byte;
                    OFS_IDX_HI: index_reg[15:8] <= req_byte;
                    OFS_IDX_LO: index_reg[7:0] <= req_byte;
                    OFS_CNT_HI: count_reg[15:8] <= req_byte;
                    OFS_CNT_LO: begin
                        count_reg[7:0] <= req_byte;
                        short_reg <= 1'b0;
                    end
                    default: begin
                    end
                endcase
                // Data beyond offset 8 is skipped until the last byte.
            end
        end
    end

    // =====================================================================
    // Reply assembly
    // =====================================================================
    // Geometry replies carry block count, block size and zero count;
    // other codes echo the request block number and byte index, with zero count and the failure bit set.
    always_comb begin
        rsp_code = code_reg | CODE_REPLY_BIT;
        if (known_code) begin
            rsp_status = STATUS_OK;
            rsp_blk = STORE_BLOCKS;
            rsp_idx = BLOCK_BYTES;
            rsp_cnt = 16'h0000;
        end else begin
            rsp_status = STATUS_FAIL;
            rsp_blk = block_reg;
            rsp_idx = index_reg;
            rsp_cnt = 16'h0000;
        end
    end

    field_be_split blk_split (
        .field_value(rsp_blk),
        .lo_byte(send_pos_reg[0]),
        .byte_out(blk_byte)
    );
    field_be_split idx_split (
        .field_value(rsp_idx),
        .lo_byte(send_pos_reg[0]),
        .byte_out(idx_byte)
    );
    field_be_split cnt_split (
        .field_value(rsp_cnt),
        .lo_byte(send_pos_reg[0]),
        .byte_out(cnt_byte)
    );

    // Reply layout mirrors the request with status in byte 1.
    always_comb begin
        unique case (send_pos_reg)
            OFS_CODE: byte_next = rsp_code;
            OFS_OPT: byte_next = rsp_status;
            OFS_BLK_HI, OFS_BLK_LO: byte_next = blk_byte;
            OFS_IDX_HI, OFS_IDX_LO: byte_next = idx_byte;
            default: byte_next = cnt_byte;
        endcase
    end

    // Output stage is registered; a byte is loaded when the stage is empty or
    // being emptied and stands until the sink takes it. The last byte may still
    // stand after the sequencer has gone back to idle.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_byte <= 8'h00;
            rsp_last <= 1'b0;
            rsp_dest_endpoint <= 8'h00;
            rsp_explicit <= 1'b0;
        end else if (clk_en) begin
            if (state_reg == ST_SEND && (!rsp_valid || rsp_ready)) begin
                rsp_valid <= 1'b1;
                rsp_byte <= byte_next;
                rsp_last <= (send_pos_reg == HDR_LAST);
                rsp_dest_endpoint <= src_ep_reg;
                rsp_explicit <= (src_ep_reg == MEM_ENDPOINT);
            end else if (rsp_valid && rsp_ready) begin
                rsp_valid <= 1'b0;
                rsp_last <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Registers and interrupt
    // =====================================================================
    // Control, mask and last-code capture.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= '0;
            last_code_reg <= 8'h00;
        end else if (clk_en) begin
            if (reg_write && reg_addr == REG_CTRL) begin
                ctrl_reg <= reg_wdata[7:0];
            end
            if (reg_write && reg_addr == REG_MASK) begin
                mask_reg <= reg_wdata[EV_WIDTH-1:0];
            end
            if (finish) begin
                last_code_reg <= code_reg;
            end
        end
    end

    assign ev_set[EV_REQUEST] = finish;
    assign ev_set[EV_REPLY] = finish && will_reply;
    assign ev_set[EV_DROPPED] = finish && !will_reply;
    assign ev_set[EV_FAIL] = finish && will_reply && !known_code;
    assign ev_clear = reg_read && (reg_addr == REG_EVENTS);

    genvar gi;
    generate
        for (gi = 0; gi < EV_WIDTH; gi++) begin : g_ev
            sticky_event ev_bit (
                .sys_clk(sys_clk),
                .rst(rst),
                .clk_en(clk_en),
                .set_pulse(ev_set[gi]),
                .clear_pulse(ev_clear),
                .flag_reg(events[gi])
            );
        end
    endgenerate

    // Read data appears only in the cycle after the read strobe.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
            irq <= 1'b0;
            busy <= 1'b0;
        end else if (clk_en) begin
            // Interrupt follows the next status value, so a set beats the read-clear.
            irq <= |(((events & ~{EV_WIDTH{ev_clear}}) | ev_set) & mask_reg);
            // Busy also covers a last reply byte still waiting for the sink.
            busy <= (state_reg != ST_IDLE) || rsp_valid;
            reg_rdata <= 32'h0000_0000;
            if (reg_read) begin
                unique case (reg_addr)
                    REG_CTRL: reg_rdata <= {24'h000000, ctrl_reg};
                    REG_EVENTS: reg_rdata <= {{(32-EV_WIDTH){1'b0}}, events};
                    REG_MASK: reg_rdata <= {{(32-EV_WIDTH){1'b0}}, mask_reg};
                    REG_STATE: reg_rdata <= {29'h0000_0000, state_reg};
                    REG_LAST_CODE: reg_rdata <= {24'h000000, last_code_reg};
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    broadcast_silent_a: assert property (@(posedge sys_clk) disable iff (rst)
        (finish && clk_en && drop_reg) |=> !rsp_valid [*8])
        else $error("reply started for a broadcast request");

    reply_code_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_SEND && send_pos_reg == OFS_CODE && known_code) |-> (rsp_code == CODE_GEOMETRY_REPLY))
        else $error("geometry reply code wrong");

    geometry_fields_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_SEND && known_code) |->
            ((send_pos_reg != OFS_BLK_LO || byte_next == STORE_BLOCKS[7:0]) &&
             (send_pos_reg != OFS_IDX_HI || byte_next == BLOCK_BYTES[15:8])))
        else $error("geometry reply fields wrong");

    irq_level_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !ev_clear && |((events | ev_set) & mask_reg)) |=> irq)
        else $error("interrupt not raised for an unmasked event");

    zero_count_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rsp_valid && rsp_last) |-> (rsp_byte == 8'h00 && $past(rsp_cnt) == 16'h0000))
        else $error("reply byte count not zero");

    unknown_fails_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_SEND && !known_code) |-> (rsp_status == STATUS_FAIL))
        else $error("unknown code not flagged as failure");

    reply_dest_a: assert property (@(posedge sys_clk) disable iff (rst)
        rsp_valid |-> (rsp_dest_endpoint == src_ep_reg && rsp_explicit == (src_ep_reg == MEM_ENDPOINT)))
        else $error("reply endpoint wrong");

    unicast_reply_a: assert property (@(posedge sys_clk) disable iff (rst)
        (finish && clk_en && will_reply) |=> (state_reg == ST_SEND) ##1 rsp_valid)
        else $error("unicast request not answered");

    foreign_ignored_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_IDLE && req_valid && !addressed) |=> (state_reg == ST_IDLE))
        else $error("foreign request accepted");
endmodule

// file: design/flash_cmd_pkg.sv
// Constants for the flash store command handler: payload layout, command codes,
// store geometry, addressing and the software register map.
// Assumes a single 250 MHz clock domain; no timing constants are needed.
package flash_cmd_pkg;
    // Store geometry.
    localparam logic [15:0] STORE_BLOCKS = 16'h0077;
    localparam logic [15:0] BLOCK_BYTES = 16'h0200;
    // Addressing of memory commands.
    localparam logic [15:0] MEM_CLUSTER = 16'h0023;
    localparam logic [7:0] MEM_ENDPOINT = 8'he6;
    // Payload byte offsets.
    localparam logic [3:0] OFS_CODE = 4'h0;
    localparam logic [3:0] OFS_OPT = 4'h1;
    localparam logic [3:0] OFS_BLK_HI = 4'h2;
    localparam logic [3:0] OFS_BLK_LO = 4'h3;
    localparam logic [3:0] OFS_IDX_HI = 4'h4;
    localparam logic [3:0] OFS_IDX_LO = 4'h5;
    localparam logic [3:0] OFS_CNT_HI = 4'h6;
    localparam logic [3:0] OFS_CNT_LO = 4'h7;
    localparam logic [3:0] HDR_LAST = 4'h7;
    localparam logic [3:0] HDR_BYTES = 4'h8;
    // Command codes.
    localparam logic [7:0] CODE_GEOMETRY_QUERY = 8'h00;
    localparam logic [7:0] CODE_GEOMETRY_REPLY = 8'h80;
    localparam logic [7:0] CODE_REPLY_BIT = 8'h80;
    // Status bits.
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [7:0] STATUS_FAIL = 8'h01;
    // Register map (word offsets in the plain register port).
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_EVENTS = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_STATE = 4'h3;
    localparam logic [3:0] REG_LAST_CODE = 4'h4;
    // Control bits.
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_ANSWER_UNKNOWN = 1;
    // Event bits.
    localparam int EV_REQUEST = 0;
    localparam int EV_REPLY = 1;
    localparam int EV_DROPPED = 2;
    localparam int EV_FAIL = 3;
    localparam int EV_WIDTH = 4;
    localparam logic [7:0] CTRL_RESET = 8'h03;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COLLECT = 3'b010,
        ST_SEND = 3'b100
    } cmd_state_e;
endpackage

// file: design/sticky_event.sv
// One sticky event bit: set by hardware, cleared by a software read.
// Assumes clock enable and synchronous reset shared with the parent.
`timescale 1ns/10ps
module sticky_event (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic set_pulse,
    input wire logic clear_pulse,
    output logic flag_reg
);
    // A set in the clearing cycle wins so that no event is lost.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else if (clk_en) begin
            if (set_pulse) begin
                flag_reg <= 1'b1;
            end else if (clear_pulse) begin
                flag_reg <= 1'b0;
            end
        end
    end
endmodule

// file: verif/requester_model.sv
// Requester model: builds memory command payloads and collects reply bytes.
// Assumes the testbench calls its tasks one at a time, from a single process.
`timescale 1ns/10ps
module requester_model
    import flash_cmd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    output logic req_valid,
    output logic [7:0] req_byte,
    output logic req_last,
    output logic req_broadcast,
    output logic [7:0] req_dest_endpoint,
    output logic [15:0] req_cluster,
    output logic [7:0] req_src_endpoint,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte,
    input wire logic rsp_last,
    input wire logic [7:0] rsp_dest_endpoint,
    input wire logic rsp_explicit,
    output logic rsp_ready
);
    logic stall = 1'b0;
    logic [7:0] got [0:15];
    int got_n = 0;
    int last_at = -1;
    logic [7:0] got_ep = 8'h00;
    logic got_expl = 1'b0;

    // ==========================================================
    // Idle levels at time zero.
    initial begin
        req_valid = 1'b0;
        req_byte = 8'h5a;
        req_last = 1'b0;
        req_broadcast = 1'b0;
        req_dest_endpoint = 8'h00;
        req_cluster = 16'h0000;
        req_src_endpoint = 8'h00;
        rsp_ready = 1'b0;
    end

    // ==========================================================
    // Payload sender: header fields go most significant byte first.
    task automatic send(input logic [7:0] code, input logic [15:0] blk, input logic [15:0] idx,
                        input logic [15:0] cnt, input int ndata, input logic bcast,
                        input logic [15:0] clu, input logic [7:0] src);
        logic [63:0] hdr;
        hdr = {code, 8'h00, blk, idx, cnt};
        @(posedge sys_clk);
        req_broadcast <= bcast;
        req_cluster <= clu;
        req_dest_endpoint <= MEM_ENDPOINT;
        req_src_endpoint <= src;
        for (int i = 0; i < 8 + ndata; i++) begin
            req_valid <= 1'b1;
            req_byte <= (i < 8) ? hdr[63 - 8 * i -: 8] : 8'(8'ha0 + i);
            req_last <= (i == 7 + ndata);
            @(posedge sys_clk);
        end
        // A released byte lane never keeps showing the last byte.
        req_valid <= 1'b0;
        req_last <= 1'b0;
        req_byte <= ~req_byte;
    endtask

    task automatic clear;
        got_n = 0;
        last_at = -1;
    endtask

    // ==========================================================
    // Reply collector; a stall toggles ready to stretch every byte.
    always @(posedge sys_clk) begin
        if (rsp_valid && rsp_ready) begin
            got[got_n] <= rsp_byte;
            if (rsp_last) begin
                last_at <= got_n;
            end
            got_n <= got_n + 1;
            got_ep <= rsp_dest_endpoint;
            got_expl <= rsp_explicit;
        end
        rsp_ready <= stall ? ~rsp_ready : 1'b1;
    end
endmodule

// file: verif/testbench.sv
// Testbench for the flash store command handler: register tasks plus payload tests.
// Assumes the requester model on the far side and a single 250 MHz clock.
`timescale 1ns/10ps
module testbench;
    import flash_cmd_pkg::*;
    logic sys_clk, rst, clk_en, reg_write, reg_read;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic req_valid, req_last, req_broadcast, rsp_valid, rsp_last, rsp_explicit, rsp_ready, busy, irq;
    logic [7:0] req_byte, req_dest_endpoint, req_src_endpoint, rsp_byte, rsp_dest_endpoint;
    logic [15:0] req_cluster;
    int num_errors = 0;
    int compares = 0;

    flash_cmd_handler dut (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .req_valid, .req_byte, .req_last, .req_broadcast, .req_dest_endpoint, .req_cluster,
        .req_src_endpoint, .rsp_valid, .rsp_byte, .rsp_last, .rsp_dest_endpoint, .rsp_explicit,
        .rsp_ready, .busy, .irq);
    requester_model host (.sys_clk, .rst, .req_valid, .req_byte, .req_last, .req_broadcast,
        .req_dest_endpoint, .req_cluster, .req_src_endpoint, .rsp_valid, .rsp_byte, .rsp_last,
        .rsp_dest_endpoint, .rsp_explicit, .rsp_ready);

    // ==========================================================
    // Clock and watchdog; the tests need well under a thousand cycles.
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #(4 * 30000);
        num_errors++;
        summarize();
    end

    // ==========================================================
    // Shared tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        repeat (4) @(posedge sys_clk);
        while ((busy !== 1'b0 || rsp_valid !== 1'b0) && k < 200) begin
            @(posedge sys_clk);
            k++;
        end
        check(32'(k == 200), 32'h0);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk_reply(input logic [7:0] code, input logic [7:0] st, input logic [15:0] blk,
                             input logic [15:0] idx, input logic [7:0] ep, input logic expl);
        logic [63:0] e;
        e = {code, st, blk, idx, 16'h0000};
        check(host.got_n, 8);
        for (int i = 0; i < 8; i++) check(host.got[i], e[63 - 8 * i -: 8]);
        check(host.last_at, 7);
        check(host.got_ep, ep);
        check(host.got_expl, expl);
    endtask
    task automatic summarize;
        $display("Errors %0d, comparisons %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check({rsp_valid, rsp_last, busy, irq}, 0);
        reg_rd(REG_CTRL, rd);
        check(rd, 32'h3);
        reg_rd(REG_STATE, rd);
        check(rd, 32'h1);
        reg_wr(4'hf, 32'hffff_ffff);
        reg_rd(4'hf, rd);
        check(rd, 32'h0);
        reg_wr(REG_MASK, 32'hf);
        // Geometry query from the device endpoint: explicit reply with store geometry.
        host.clear();
        host.send(8'h00, 16'h0, 16'h0, 16'h0, 0, 1'b0, MEM_CLUSTER, 8'he6);
        wait_done();
        chk_reply(8'h80, 8'h00, 16'h0077, 16'h0200, 8'he6, 1'b1);
        check(irq, 1'b1);
        reg_rd(REG_EVENTS, rd);
        check(rd, 32'h3);
        reg_rd(REG_EVENTS, rd);
        check(rd, 32'h0);
        check(irq, 1'b0);
        // A write while the clock enable is low must leave the mask untouched.
        clk_en <= 1'b0;
        reg_wr(REG_MASK, 32'h0);
        clk_en <= 1'b1;
        reg_rd(REG_MASK, rd);
        check(rd, 32'hf);
        // Broadcast and foreign cluster requests get no reply.
        host.clear();
        host.send(8'h00, 16'h0, 16'h0, 16'h0, 0, 1'b1, MEM_CLUSTER, 8'he6);
        wait_done();
        check(host.got_n, 0);
        reg_rd(REG_EVENTS, rd);
        check(rd[EV_DROPPED], 1'b1);
        host.send(8'h00, 16'h0, 16'h0, 16'h0, 0, 1'b0, 16'h0024, 8'he6);
        wait_done();
        check(host.got_n, 0);
        // Unknown code with data bytes, a stalling sink and every event masked.
        reg_wr(REG_MASK, 32'h0);
        host.stall = 1'b1;
        host.send(8'h05, 16'h1234, 16'habcd, 16'h0003, 3, 1'b0, MEM_CLUSTER, 8'h41);
        wait_done();
        chk_reply(8'h85, 8'h01, 16'h1234, 16'habcd, 8'h41, 1'b0);
        check(irq, 1'b0);
        reg_rd(REG_EVENTS, rd);
        check(rd[EV_FAIL], 1'b1);
        reg_rd(REG_LAST_CODE, rd);
        check(rd[7:0], 8'h05);
        // Unknown codes dropped once answering them is off, everything once disabled.
        host.stall = 1'b0;
        host.clear();
        reg_wr(REG_CTRL, 32'h1);
        host.send(8'h05, 16'h0, 16'h0, 16'h0, 0, 1'b0, MEM_CLUSTER, 8'he6);
        wait_done();
        check(host.got_n, 0);
        reg_wr(REG_CTRL, 32'h0);
        host.send(8'h00, 16'h0, 16'h0, 16'h0, 0, 1'b0, MEM_CLUSTER, 8'he6);
        wait_done();
        check(host.got_n, 0);
        summarize();
    end
endmodule
